// ### logic/ksw_pkg.sv
// Purpose: constants for the key-serviced rc watchdog control logic
// Assumes: 250 MHz system clock
// Notes: key values are 9-bit words as written by software
`default_nettype none
package ksw_pkg;
  localparam int KEY_W = 9;
  localparam logic [KEY_W-1:0] KEY_ARM = 9'h0e5;
  localparam logic [KEY_W-1:0] KEY_CLEAR = 9'h0a3;
  localparam int DISCHARGE_CYCLES = 256;
  localparam logic [8:0] DISCHARGE_LAST = 9'h0ff;
  localparam logic [8:0] CNT_RESET = 9'h000;
  localparam logic ARMED_RESET = 1'b0;
  localparam logic CAUSE_RESET = 1'b0;
endpackage
`default_nettype wire

// ### logic/ksw_watchdog.sv
// Purpose: key-serviced rc watchdog: key sequence, pin discharge, trip reset
// Assumes: key writes are one-cycle strobes from logic on clock_i
// Notes: the pin is open drain, pulled low only; the rc network sets the timeout
//
// Functional notes
// [R1] arm key then clear key discharges the capacitor, restarting the delay
// [R2] any other key value written raises an immediate system reset
// [R3] arm sets armed; repeated arms keep it; clear only acts while armed
// [R4] after valid clear, sink pin current exactly 256 cycles then release
// [R5] pin reading high after threshold crossing raises a system reset
// [R6] software must service often enough that the pin never reaches threshold
// [R7] in test mode watchdog resets are suppressed
// [R8] a watchdog reset sets its own sticky reset-cause flag
// [R9] pin level is synchronised through two flip-flops before use
`default_nettype none
module ksw_watchdog
  import ksw_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // key register write port
  input wire logic key_wr_i,
  input wire logic [KEY_W-1:0] key_data_i,
  // mode and cause flag control
  input wire logic test_mode_i,
  input wire logic cause_clr_i,
  // rc watchdog pin, open drain
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe_n_o,
  // status and reset request
  output logic armed_o,
  output logic sys_reset_req_o,
  output logic cause_flag_o
);

  //////////////////////////////////////////////////////////////////////////////
  logic sync1_reg, sync2_reg;
  logic armed_reg, armed_next;
  logic dis_reg, dis_next;
  logic [8:0] cnt_reg, cnt_next;
  logic cause_reg, cause_next;
  logic req_reg, req_next;
  logic bad_key, good_clear, trip;

  // [R9] two-stage pin sync
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= pin_i;
      sync2_reg <= sync1_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    // [R2] illegal key value
    bad_key = key_wr_i && (key_data_i != KEY_ARM) && (key_data_i != KEY_CLEAR);
    // [R1] legal service completes
    good_clear = key_wr_i && (key_data_i == KEY_CLEAR) && armed_reg;
    // [R5] threshold crossing
    trip = sync2_reg;
    // [R3] arm state
    armed_next = armed_reg;
    if (key_wr_i && key_data_i == KEY_ARM) begin
      armed_next = 1'b1;
    end else if (good_clear) begin
      armed_next = 1'b0;
    end
    // [R4] discharge window, restarts on each valid clear
    dis_next = dis_reg;
    cnt_next = cnt_reg;
    if (good_clear) begin
      dis_next = 1'b1;
      cnt_next = CNT_RESET;
    end else if (dis_reg) begin
      cnt_next = cnt_reg + 9'h001;
      if (cnt_reg == DISCHARGE_LAST) begin
        dis_next = 1'b0;
      end
    end
    // [R7] test mode masks the request
    req_next = (bad_key || trip) && !test_mode_i;
    // [R8] sticky cause flag, set wins over clear
    cause_next = cause_reg;
    if (req_next) begin
      cause_next = 1'b1;
    end else if (cause_clr_i) begin
      cause_next = 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      armed_reg <= ARMED_RESET;
      dis_reg <= 1'b0;
      cnt_reg <= CNT_RESET;
      cause_reg <= CAUSE_RESET;
      req_reg <= 1'b0;
    end else begin
      armed_reg <= armed_next;
      dis_reg <= dis_next;
      cnt_reg <= cnt_next;
      cause_reg <= cause_next;
      req_reg <= req_next;
    end
  end

  // pin only ever pulled low; enable is active low
  assign pin_o = 1'b0;
  assign pin_oe_n_o = ~dis_reg;
  assign armed_o = armed_reg;
  assign sys_reset_req_o = req_reg;
  assign cause_flag_o = cause_reg;

  //////////////////////////////////////////////////////////////////////////////
  property p_bad_key_reset;
    @(posedge clock_i) disable iff (!rst_n_i)
      (key_wr_i && key_data_i != KEY_ARM && key_data_i != KEY_CLEAR && !test_mode_i)
      |=> sys_reset_req_o;
  endproperty
  a_bad_key_reset: assert property (p_bad_key_reset) else $error("bad key no reset"); // [R2]

  property p_clear_starts;
    @(posedge clock_i) disable iff (!rst_n_i)
      (key_wr_i && key_data_i == KEY_CLEAR && armed_o) |=> !pin_oe_n_o && !armed_o;
  endproperty
  a_clear_starts: assert property (p_clear_starts) else $error("clear did not discharge"); // [R1]

  property p_sink_cause;
    @(posedge clock_i) disable iff (!rst_n_i)
      $fell(pin_oe_n_o) |-> $past(good_clear);
  endproperty
  a_sink_cause: assert property (p_sink_cause) else $error("sink without service"); // [R1]

  property p_arm_sets;
    @(posedge clock_i) disable iff (!rst_n_i)
      (key_wr_i && key_data_i == KEY_ARM) |=> armed_o;
  endproperty
  a_arm_sets: assert property (p_arm_sets) else $error("arm key not armed"); // [R3]

  property p_unarmed_clear;
    @(posedge clock_i) disable iff (!rst_n_i)
      (key_wr_i && key_data_i == KEY_CLEAR && !armed_o && pin_oe_n_o)
      |=> pin_oe_n_o && !armed_o;
  endproperty
  a_unarmed_clear: assert property (p_unarmed_clear) else $error("unarmed clear acted"); // [R3]

  property p_unarmed_hold;
    @(posedge clock_i) disable iff (!rst_n_i)
      (!armed_o && !(key_wr_i && key_data_i == KEY_ARM)) |=> !armed_o;
  endproperty
  a_unarmed_hold: assert property (p_unarmed_hold) else $error("armed without key"); // [R3]

  property p_discharge_len;
    @(posedge clock_i) disable iff (!rst_n_i)
      (!pin_oe_n_o && cnt_reg == DISCHARGE_LAST && !good_clear) |=> pin_oe_n_o;
  endproperty
  a_discharge_len: assert property (p_discharge_len) else $error("sink not released"); // [R4]

  property p_clear_restart;
    @(posedge clock_i) disable iff (!rst_n_i)
      (!pin_oe_n_o && good_clear) |=> (!pin_oe_n_o && cnt_reg == CNT_RESET);
  endproperty
  a_clear_restart: assert property (p_clear_restart) else $error("no restart"); // [R4]

  // counts low cycles of the enable; a clear mid-sink restarts the count
  logic [9:0] low_len;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_len <= 10'h000;
    end else begin
      low_len <= (pin_oe_n_o || good_clear) ? 10'h000 : low_len + 10'h001;
    end
  end
  property p_discharge_max;
    @(posedge clock_i) disable iff (!rst_n_i)
      low_len <= 10'(DISCHARGE_CYCLES);
  endproperty
  a_discharge_max: assert property (p_discharge_max) else $error("discharge too long"); // [R4]

  property p_discharge_end;
    @(posedge clock_i) disable iff (!rst_n_i)
      ($rose(pin_oe_n_o) && !$past(key_wr_i)) |-> low_len == 10'(DISCHARGE_CYCLES);
  endproperty
  a_discharge_end: assert property (p_discharge_end) else $error("discharge width wrong"); // [R4]

  property p_trip_reset;
    @(posedge clock_i) disable iff (!rst_n_i)
      (pin_i && !test_mode_i) ##1 (!test_mode_i) ##1 !test_mode_i |=> sys_reset_req_o;
  endproperty
  a_trip_reset: assert property (p_trip_reset) else $error("trip no reset"); // [R5]

  property p_test_mask;
    @(posedge clock_i) disable iff (!rst_n_i)
      test_mode_i |=> !sys_reset_req_o;
  endproperty
  a_test_mask: assert property (p_test_mask) else $error("reset in test mode"); // [R7]

  property p_cause_set;
    @(posedge clock_i) disable iff (!rst_n_i)
      sys_reset_req_o |-> cause_flag_o;
  endproperty
  a_cause_set: assert property (p_cause_set) else $error("cause flag missing"); // [R8]

  property p_bad_key_cause;
    @(posedge clock_i) disable iff (!rst_n_i)
      (key_wr_i && key_data_i != KEY_ARM && key_data_i != KEY_CLEAR && !test_mode_i)
      |=> cause_flag_o;
  endproperty
  a_bad_key_cause: assert property (p_bad_key_cause) else $error("bad key no cause"); // [R8]

  property p_sync_delay;
    @(posedge clock_i) disable iff (!rst_n_i)
      (!pin_i ##1 !pin_i) |=> !sync2_reg;
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("sync too fast"); // [R9]

  // exact two-edge latency, skipped until both stages hold post-reset samples
  property p_sync_exact;
    @(posedge clock_i) disable iff (!rst_n_i)
      ($past(rst_n_i) && $past(rst_n_i, 2)) |-> sync2_reg == $past(pin_i, 2);
  endproperty
  a_sync_exact: assert property (p_sync_exact) else $error("sync latency wrong"); // [R9]

endmodule // ksw_watchdog
`default_nettype wire

// ### test/ksw_rc_model.sv
// Purpose: rc network on the watchdog pin
// Assumes: one charge step per cycle
// Notes: a sink drains eight steps per cycle
`default_nettype none
module ksw_rc_model #(parameter int TRIP = 600) (
  // clock
  input wire logic clock_i,
  // pin side
  input wire logic oe_n_i,
  output logic level_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int v = 0;
  always @(posedge clock_i) v <= oe_n_i ? v + 1 : (v > 8 ? v - 8 : 0);
  assign level_o = v >= TRIP;
endmodule // ksw_rc_model
`default_nettype wire

// ### test/tb_ksw_watchdog.sv
// Purpose: self-checking bench for the watchdog
// Assumes: model trips after about 600 idle cycles
// Notes: keys are one-cycle strobes
`default_nettype none
module tb_ksw_watchdog import ksw_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 0, rst_n_i = 0, key_wr_i = 0, test_mode_i = 0, cause_clr_i = 0;
  logic [KEY_W-1:0] key_data_i = '0, k;
  logic lvl, pin_o, pin_oe_n_o, armed_o, sys_reset_req_o, cause_flag_o;
  wire logic pin_w;
  int seed = 70, mismatches = 0, samples_checked = 0, n;
  always #2 clock_i = ~clock_i;
  // sinking wins over the network
  assign pin_w = pin_oe_n_o ? lvl : pin_o;
  ksw_rc_model rc (.clock_i(clock_i), .oe_n_i(pin_oe_n_o), .level_o(lvl));
  ksw_watchdog uut (.clock_i(clock_i), .rst_n_i(rst_n_i), .key_wr_i(key_wr_i),
    .key_data_i(key_data_i), .test_mode_i(test_mode_i), .cause_clr_i(cause_clr_i),
    .pin_i(pin_w), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o), .armed_o(armed_o),
    .sys_reset_req_o(sys_reset_req_o), .cause_flag_o(cause_flag_o));
  function automatic logic legal(input logic [KEY_W-1:0] v);
    return v == KEY_ARM || v == KEY_CLEAR;
  endfunction
  task automatic chk(input logic g, input logic e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chkn(input int g, input int e);
    samples_checked++;
    if (g != e) begin
      mismatches++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [KEY_W-1:0] v);
    @(posedge clock_i) key_wr_i <= 1'b1;
    key_data_i <= v;
    @(posedge clock_i) key_wr_i <= 1'b0;
    #1;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clock_i);
    rst_n_i <= 1'b1;
    wr(KEY_CLEAR);
    chk(armed_o, 1'b0); // not armed
    chk(pin_oe_n_o, 1'b1); // no sink
    repeat (3) wr(KEY_ARM);
    chk(armed_o, 1'b1); // armed
    wr(KEY_CLEAR);
    chk(armed_o, 1'b0); // disarmed
    chk(pin_o, 1'b0); // sink low
    n = 0;
    while (pin_oe_n_o === 1'b0 && n < 300) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    chkn(n, DISCHARGE_CYCLES); // sink length
    wr(KEY_ARM);
    wr(KEY_CLEAR);
    repeat (100) @(posedge clock_i);
    wr(KEY_ARM);
    wr(KEY_CLEAR);
    n = 0;
    while (pin_oe_n_o === 1'b0 && n < 300) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    chkn(n, DISCHARGE_CYCLES); // restart length
    $display("test service done");
    k = 9'h023;
    repeat (5) begin
      if (legal(k))
        k[0] = ~k[0];
      wr(k);
      chk(sys_reset_req_o, !legal(k)); // bad key
      chk(cause_flag_o, 1'b1); // cause set
      k = KEY_W'($random(seed));
    end
    $display("test bad key done");
    @(posedge clock_i) cause_clr_i <= 1'b1;
    @(posedge clock_i) cause_clr_i <= 1'b0;
    test_mode_i <= 1'b1;
    wr(9'h023);
    chk(sys_reset_req_o, 1'b0); // masked
    chk(cause_flag_o, 1'b0); // no flag
    @(posedge clock_i) test_mode_i <= 1'b0;
    $display("test mode done");
    repeat (4) begin
      wr(KEY_ARM);
      wr(KEY_CLEAR);
      repeat (400) @(posedge clock_i);
    end
    chk(cause_flag_o, 1'b0); // no trip
    n = 0;
    while (sys_reset_req_o !== 1'b1 && n < 1000) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    chk(sys_reset_req_o, 1'b1); // trip
    chk(cause_flag_o, 1'b1); // cause set
    $display("test trip done");
    report_and_stop;
  end
endmodule // tb_ksw_watchdog
`default_nettype wire
